// file: core/cmp_pkg.sv
// Package with register map, field positions and reset values of the comparator control block.
package cmp_pkg;
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] port_addr = 4'h1;
  localparam logic [3:0] stat_addr = 4'h2;
  localparam int sel_bit = 7;
  localparam int on_bit = 6;
  localparam int inv_bit = 5;
  localparam int res_bit = 4;
  localparam int path_bit = 3;
  localparam int edge_hi_bit = 2;
  localparam int edge_lo_bit = 1;
  localparam int hyst_bit = 0;
  localparam logic [7:0] ctrl_reset = 8'h81;
  localparam logic [7:0] ctrl_wmask = 8'hef;
  localparam int port_dir_bit = 0;
  localparam int port_data_bit = 1;
  localparam int flag_bit = 0;
  localparam int sleep_bit = 1;
  localparam logic [1:0] edge_rise = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;
  typedef enum logic [1:0] {st_idle = 2'h0, st_answer = 2'h1} bus_state_t;
endpackage

// file: core/sync2.sv
// Two-stage synchroniser for asynchronous single-bit levels.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int width = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Data.
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1_reg;

  // Only the second stage reads the first, keeping metastability contained.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// file: core/comparator_ctrl.sv
// Digital control and status logic around an analog voltage comparator.
//
// Summary of operation
// - Select bit set connects shared pins to comparator inputs, dropping other functions.
// - Pull-high resistors on comparator pins drop out whenever the comparator owns them.
// - On/off bit zero powers the comparator down; one powers it up.
// - Polarity bit zero passes decision straight, one inverts it.
// - Result bit reads one when plus exceeds minus, swapped when inverted.
// - Path bit zero drives the output pin; one keeps result internal only.
// - Edge field: 00 rising, 01 falling, 1x both edges set the flag.
// - Hysteresis bit adds hysteresis when set; it resets to one.
// - Selected result edge sets the flag and requests interrupt when enabled.
// - Interrupts follow internal result bit after polarity, never the output pin.
// - In sleep or idle, a flag-raising change also raises wake-up.
// - Enabled comparator keeps running and updating during sleep or idle.
// - With pins owned, port read gives zero if direction one, else data.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module comparator_ctrl (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Analog comparator macro.
  input wire logic cmp_raw,
  output logic cmp_power_on,
  output logic hyst_enable,
  output logic inputs_connected,
  output logic pullup_disable,
  // Output pin and processor side.
  output logic compare_out_pin,
  output logic compare_out_pin_oe,
  input wire logic irq_enable,
  input wire logic low_power_mode,
  output logic irq_request,
  output logic wakeup_request
);
  logic [7:0] ctrl_reg;
  logic [1:0] port_reg;
  logic flag_reg;
  logic result_reg;
  logic result_prev_reg;
  logic sync_raw;
  logic sync_sleep;
  logic edge_hit;
  logic rise;
  logic fall;
  logic wr_ctrl;
  logic wr_stat;
  cmp_pkg::bus_state_t state_reg;

  // Decode a register hit for one offset; used by reads and writes alike.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // Raw decision and the low-power indication are asynchronous to this clock.
  sync2 #(.width(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({low_power_mode, cmp_raw}),
    .sync_out({sync_sleep, sync_raw})
  );

  // Bus handshake: every access takes exactly one wait cycle, so readdata is registered.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= cmp_pkg::st_idle;
    else
    begin
      unique case (state_reg)
        cmp_pkg::st_idle:
          if (read || write)
            state_reg <= cmp_pkg::st_answer;
        cmp_pkg::st_answer:
          state_reg <= cmp_pkg::st_idle;
        default:
          state_reg <= cmp_pkg::st_idle;
      endcase
    end
  end

  // Waitrequest is high unless an answer cycle is in progress.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && state_reg == cmp_pkg::st_idle);
  end

  assign wr_ctrl = write && state_reg == cmp_pkg::st_answer && hit(address, cmp_pkg::ctrl_addr);
  assign wr_stat = write && state_reg == cmp_pkg::st_answer && hit(address, cmp_pkg::stat_addr);

  // Control register; the result bit is read-only and ignores writes.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= cmp_pkg::ctrl_reset;
    else if (wr_ctrl)
      ctrl_reg <= writedata[7:0] & cmp_pkg::ctrl_wmask;
  end

  // Port direction and data bits of the shared pin.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      port_reg <= 2'h0;
    else if (write && state_reg == cmp_pkg::st_answer && hit(address, cmp_pkg::port_addr))
      port_reg <= writedata[1:0];
  end

  // Result bit follows the synchronised decision only while powered.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg <= 1'b0;
      result_prev_reg <= 1'b0;
    end
    else
    begin
      if (ctrl_reg[cmp_pkg::on_bit])
        result_reg <= sync_raw ^ ctrl_reg[cmp_pkg::inv_bit];
      result_prev_reg <= result_reg;
    end
  end

  // Edges come from the internal result bit, never from the pin.
  assign rise = result_reg && !result_prev_reg;
  assign fall = !result_reg && result_prev_reg;

  always_comb
  begin
    if (ctrl_reg[cmp_pkg::edge_hi_bit])
      edge_hit = rise || fall;
    else if (ctrl_reg[cmp_pkg::edge_lo_bit])
      edge_hit = fall;
    else
      edge_hit = rise;
  end

  // Sticky flag; software writes one to set, zero to clear; a new edge beats a clear.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else if (edge_hit)
      flag_reg <= 1'b1;
    else if (wr_stat)
      flag_reg <= writedata[cmp_pkg::flag_bit];
  end

  // Interrupt and wake-up requests; a pre-set flag produces no new wake-up.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_request <= 1'b0;
      wakeup_request <= 1'b0;
    end
    else
    begin
      irq_request <= flag_reg && irq_enable;
      wakeup_request <= edge_hit && !flag_reg && sync_sleep
        && ctrl_reg[cmp_pkg::on_bit];
    end
  end

  // Analog controls and pin routing, registered for clean outputs.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_power_on <= 1'b0;
      hyst_enable <= 1'b1;
      inputs_connected <= 1'b1;
      pullup_disable <= 1'b1;
      compare_out_pin <= 1'b0;
      compare_out_pin_oe <= 1'b0;
    end
    else
    begin
      cmp_power_on <= ctrl_reg[cmp_pkg::on_bit];
      hyst_enable <= ctrl_reg[cmp_pkg::hyst_bit];
      inputs_connected <= ctrl_reg[cmp_pkg::sel_bit];
      pullup_disable <= ctrl_reg[cmp_pkg::sel_bit];
      compare_out_pin <= result_reg;
      compare_out_pin_oe <= !ctrl_reg[cmp_pkg::path_bit];
    end
  end

  // Read data, registered in the wait cycle; unmapped offsets read zero.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readdata <= 32'h0;
    else if (read && state_reg == cmp_pkg::st_idle)
    begin
      readdata <= 32'h0;
      if (hit(address, cmp_pkg::ctrl_addr))
      begin
        readdata[7:0] <= ctrl_reg;
        readdata[cmp_pkg::res_bit] <= result_reg;
      end
      else if (hit(address, cmp_pkg::port_addr))
      begin
        readdata[cmp_pkg::port_dir_bit] <= port_reg[cmp_pkg::port_dir_bit];
        if (ctrl_reg[cmp_pkg::sel_bit])
          readdata[cmp_pkg::port_data_bit] <= port_reg[cmp_pkg::port_dir_bit] ? 1'b0
            : port_reg[cmp_pkg::port_data_bit];
        else
          readdata[cmp_pkg::port_data_bit] <= port_reg[cmp_pkg::port_data_bit];
      end
      else if (hit(address, cmp_pkg::stat_addr))
      begin
        readdata[cmp_pkg::flag_bit] <= flag_reg;
        readdata[cmp_pkg::sleep_bit] <= sync_sleep;
      end
    end
  end

  // Assertions.
  reset_value_a: assert property (@(posedge clock) $rose(rst_n) |-> hyst_enable)
    else $error("hysteresis not on after reset");
  power_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmp_power_on == $past(ctrl_reg[cmp_pkg::on_bit]))
    else $error("power control lags control bit");
  result_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(ctrl_reg[cmp_pkg::on_bit]) |-> result_reg == ($past(sync_raw)
      ^ $past(ctrl_reg[cmp_pkg::inv_bit])))
    else $error("result bit wrong polarity");
  rise_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rise && ctrl_reg[2:1] == cmp_pkg::edge_rise) |=> flag_reg)
    else $error("rising edge missed");
  fall_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (rise && !fall && ctrl_reg[2:1] == cmp_pkg::edge_fall && !flag_reg && !wr_stat)
      |=> !flag_reg)
    else $error("rising edge set flag in falling mode");
  irq_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    (flag_reg && irq_enable) |=> irq_request)
    else $error("interrupt request missing");
  pin_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> compare_out_pin_oe == !$past(ctrl_reg[cmp_pkg::path_bit]))
    else $error("output pin routing wrong");
  pullup_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(ctrl_reg[cmp_pkg::sel_bit]) |-> pullup_disable && inputs_connected)
    else $error("pull-high still connected");
  wake_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    (edge_hit && !flag_reg && sync_sleep && ctrl_reg[cmp_pkg::on_bit])
      |=> wakeup_request)
    else $error("wake-up missing");

  // Named steps shared by the properties below.
  // An access is taken while the handshake is idle.
  sequence access_taken_s;
    (read || write) && state_reg == cmp_pkg::st_idle;
  endsequence

  // The answer cycle: waitrequest low while the handshake sits in its answer state.
  sequence answer_given_s;
    !waitrequest && state_reg == cmp_pkg::st_answer;
  endsequence

  // A selected edge of the result bit followed by the raised flag one cycle on.
  sequence flag_raised_s;
    edge_hit ##1 flag_reg;
  endsequence

  // Conditions under which a wake-up must follow: a selected edge while sleeping, powered, flag still clear.
  sequence wake_cause_s;
    edge_hit && !flag_reg && sync_sleep && ctrl_reg[cmp_pkg::on_bit];
  endsequence

  // Exactly one wait state, so a master that waits for the answer never hangs here.
  wait_state_a: assert property (@(posedge clock) disable iff (!rst_n)
    access_taken_s |=> answer_given_s)
    else $error("bus answer not given after one wait");

  // Waitrequest drops for one cycle only, so a stale answer cannot close a later access.
  answer_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Every selected edge raises the flag on the next cycle, whatever software writes.
  flag_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    edge_hit |-> flag_raised_s)
    else $error("selected edge did not raise the flag");

  // Falling-only mode must catch a falling result edge.
  fall_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall && ctrl_reg[cmp_pkg::edge_hi_bit:cmp_pkg::edge_lo_bit] == cmp_pkg::edge_fall)
      |=> flag_reg)
    else $error("falling edge missed");

  // With the upper edge bit set, falling edges count as well as rising ones.
  both_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fall && ctrl_reg[cmp_pkg::edge_hi_bit]) |=> flag_reg)
    else $error("falling edge missed in both-edge mode");

  // The flag is sticky: only a status write can take it down.
  sticky_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (flag_reg && !wr_stat) |=> flag_reg)
    else $error("flag lost without a clear");

  // No edge and no write leaves a clear flag clear.
  flag_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!flag_reg && !edge_hit && !wr_stat) |=> !flag_reg)
    else $error("flag raised without a cause");

  // The interrupt request falls once flag or enable is gone.
  irq_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(flag_reg && irq_enable) |=> !irq_request)
    else $error("interrupt request without flag and enable");

  // A pre-set flag or an awake processor gives no wake-up pulse.
  wake_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(edge_hit && !flag_reg && sync_sleep && ctrl_reg[cmp_pkg::on_bit])
      |=> !wakeup_request)
    else $error("wake-up without a cause");

  // A powered-down comparator leaves the result bit where it was.
  result_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(ctrl_reg[cmp_pkg::on_bit]) |-> $stable(result_reg))
    else $error("result moved while powered down");

  // The stored copy of the result bit stays zero; reads take the live bit instead.
  result_ro_a: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl_reg[cmp_pkg::res_bit])
    else $error("result bit written by software");

  // The output pin shows the result bit one cycle late.
  pin_value_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> compare_out_pin == $past(result_reg))
    else $error("output pin does not follow result");

  // Hysteresis control follows its bit one cycle late.
  hyst_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> hyst_enable == $past(ctrl_reg[cmp_pkg::hyst_bit]))
    else $error("hysteresis control lags its bit");

  // Released pins get their pull-highs and other functions back.
  pins_free_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(rst_n) && !$past(ctrl_reg[cmp_pkg::sel_bit]))
      |-> !pullup_disable && !inputs_connected)
    else $error("pins still held by comparator");

  // A wake cause always yields the pulse, stated through the named step.
  wake_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
    wake_cause_s |=> wakeup_request)
    else $error("wake-up pulse missing after cause");
endmodule
`default_nettype wire

// file: tb/analog_inputs.sv
// Behavioural model of the two analog voltages on the comparator input pins.
`timescale 1ns/10ps
`default_nettype none
module analog_inputs (
  // Pin voltages in arbitrary steps.
  input wire logic [7:0] v_plus,
  input wire logic [7:0] v_minus,
  // Macro state.
  input wire logic powered,
  output logic cmp_raw
);
  logic junk = 1'b0;
  // An unpowered macro gives no valid decision, so a drifting level shows it.
  always #37 junk = ~junk;
  // The decision is asynchronous to the system clock.
  assign cmp_raw = powered ? (v_plus > v_minus) : junk;
endmodule
`default_nettype wire

// file: tb/analog_comparator_control_bench.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_control_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, cmp_raw, cmp_power_on, hyst_enable, inputs_connected;
  logic pullup_disable, compare_out_pin, compare_out_pin_oe, irq_request, wakeup_request;
  logic irq_enable = 1'b1;
  logic low_power_mode = 1'b0;
  logic [7:0] v_plus = 8'h10;
  logic [7:0] v_minus = 8'h20;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int wakes = 0;

  // System clock at 40 MHz.
  always #12.5 clock = ~clock;

  comparator_ctrl dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cmp_raw(cmp_raw), .cmp_power_on(cmp_power_on), .hyst_enable(hyst_enable),
    .inputs_connected(inputs_connected), .pullup_disable(pullup_disable),
    .compare_out_pin(compare_out_pin), .compare_out_pin_oe(compare_out_pin_oe),
    .irq_enable(irq_enable), .low_power_mode(low_power_mode), .irq_request(irq_request),
    .wakeup_request(wakeup_request));

  analog_inputs analog (.v_plus(v_plus), .v_minus(v_minus),
    .powered(cmp_power_on & inputs_connected), .cmp_raw(cmp_raw));

  // Hang guard and tally of wake-up pulses.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (wakeup_request === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // One Avalon access; the request stands until waitrequest is seen low.
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Compares one value and reports a mismatch.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Sets the pin voltages and lets the sync, result and flag stages settle.
  task automatic set_volts(input logic [7:0] p, input logic [7:0] m);
    @(posedge clock);
    v_plus <= p;
    v_minus <= m;
    repeat (9) @(posedge clock);
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence; in the edge loop the flag is cleared before each edge so only one edge counts.
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("ctrl reset", {24'h0, cmp_pkg::ctrl_reset}, rd);
    check("hysteresis", 32'h1, hyst_enable);
    check("pins owned", 32'h1, inputs_connected);
    check("pullups off", 32'h1, pullup_disable);
    check("power", 32'h0, cmp_power_on);
    $display("Test reset done");
    xfer(1'b1, cmp_pkg::ctrl_addr, 32'hd0);
    set_volts(8'h10, 8'h20);
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("ctrl low", 32'hc0, rd);
    check("power", 32'h1, cmp_power_on);
    set_volts(8'h30, 8'h20);
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("ctrl high", 32'hd0, rd);
    check("pin", 32'h1, compare_out_pin);
    check("pin oe", 32'h1, compare_out_pin_oe);
    xfer(1'b1, cmp_pkg::ctrl_addr, 32'he0);
    set_volts(8'h30, 8'h20);
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("ctrl inverted", 32'he0, rd);
    check("pin inverted", 32'h0, compare_out_pin);
    $display("Test polarity done");
    for (int m = 0; m < 4; m++)
    begin
      irq_enable <= m[0];
      set_volts(8'h10, 8'h20);
      xfer(1'b1, cmp_pkg::ctrl_addr, 32'hc8 | (32'(m) << 1));
      xfer(1'b1, cmp_pkg::stat_addr, 32'h0);
      set_volts(8'h30, 8'h20);
      xfer(1'b0, cmp_pkg::stat_addr, 32'h0);
      check("rise flag", 32'(m != 1), rd & 32'h1);
      check("irq", 32'(m == 3), irq_request);
      check("pin oe off", 32'h0, compare_out_pin_oe);
      check("hyst off", 32'h0, hyst_enable);
      xfer(1'b1, cmp_pkg::stat_addr, 32'h0);
      set_volts(8'h10, 8'h20);
      xfer(1'b0, cmp_pkg::stat_addr, 32'h0);
      check("fall flag", 32'(m != 0), rd & 32'h1);
    end
    $display("Test edges done");
    low_power_mode <= 1'b1;
    xfer(1'b1, cmp_pkg::ctrl_addr, 32'hc4);
    xfer(1'b1, cmp_pkg::stat_addr, 32'h0);
    set_volts(8'h30, 8'h20);
    check("wake", 32'h1, wakes);
    xfer(1'b0, cmp_pkg::stat_addr, 32'h0);
    check("sleep status", 32'h3, rd);
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("sleep result", 32'hd4, rd);
    xfer(1'b1, cmp_pkg::stat_addr, 32'h1);
    set_volts(8'h10, 8'h20);
    check("blocked wake", 32'h1, wakes);
    xfer(1'b1, cmp_pkg::ctrl_addr, 32'h84);
    set_volts(8'h30, 8'h20);
    check("power off", 32'h0, cmp_power_on);
    xfer(1'b0, cmp_pkg::ctrl_addr, 32'h0);
    check("held result", 32'h84, rd);
    low_power_mode <= 1'b0;
    $display("Test sleep done");
    xfer(1'b1, cmp_pkg::port_addr, 32'h3);
    xfer(1'b0, cmp_pkg::port_addr, 32'h0);
    check("port dir one", 32'h1, rd);
    xfer(1'b1, cmp_pkg::port_addr, 32'h2);
    xfer(1'b0, cmp_pkg::port_addr, 32'h0);
    check("port dir zero", 32'h2, rd);
    xfer(1'b1, cmp_pkg::ctrl_addr, 32'h04);
    xfer(1'b1, cmp_pkg::port_addr, 32'h3);
    xfer(1'b0, cmp_pkg::port_addr, 32'h0);
    check("port free", 32'h3, rd);
    check("pins free", 32'h0, inputs_connected);
    check("pullups on", 32'h0, pullup_disable);
    xfer(1'b0, 4'hf, 32'h0);
    check("unmapped", 32'h0, rd);
    $display("Test ports done");
    finish_test();
  end
endmodule
`default_nettype wire
